// ### logic/fcs_synth_top.sv
// fractional clock synthesizer with avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none
module fcs_synth_top #(
  parameter int unsigned REF_TIMEOUT_CYC = fcs_pkg::FCS_REF_TIMEOUT_CYC,
  parameter int unsigned PERIOD_W        = fcs_pkg::FCS_PERIOD_W
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reference_clock_in,
  input  wire logic        i_feedback_clock_in,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_synth_clock_out,
  output logic             o_synth_clock_out_inverted,
  output logic             o_zero_phase_clock_out,
  output logic             o_locked
);

  localparam int unsigned RW    = fcs_pkg::FCS_RATIO_W;
  localparam int unsigned TGT_W = PERIOD_W + RW;
  localparam int unsigned ACC_W = TGT_W + 1;
  localparam logic [PERIOD_W-1:0] TIMEOUT_LIM = PERIOD_W'(REF_TIMEOUT_CYC - 1);
  localparam logic [ACC_W-1:0]    LOW_HALF    = ACC_W'(fcs_pkg::FCS_LOW_MIN_HALF_CYC);
  localparam logic [6:0]          RISE_SAT    = 7'h7F;

  // pin inputs
  logic ref_s;
  logic fb_s;
  logic ref_d_reg;
  logic fb_d_reg;
  logic ref_rise;
  logic fb_rise;

  // reference and feedback share one synchronizer; both come from pins
  fcs_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_feedback_clock_in, i_reference_clock_in}),
    .o_sync  ({fb_s, ref_s})
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ref_d_reg <= 1'b0;
      fb_d_reg  <= 1'b0;
    end else begin
      ref_d_reg <= ref_s;
      fb_d_reg  <= fb_s;
    end
  end

  assign ref_rise = ref_s & ~ref_d_reg;
  assign fb_rise  = fb_s & ~fb_d_reg;

  // bus slave: one wait cycle, then waitrequest low for one cycle
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic        bus_req;
  logic        wr_take;
  logic        rd_take;

  assign bus_req = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & ~wait_reg & i_avs_byteenable[0];
  assign rd_take = i_avs_read & wait_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_mux;
    end
  end

  // configuration
  logic                run_reg;
  fcs_pkg::fcs_speed_t speed_reg;
  fcs_pkg::fcs_fb_sel_t fb_sel_reg;
  logic [RW-1:0]       numer_reg;
  logic [RW-1:0]       denom_reg;
  logic                cfg_touch;

  assign cfg_touch = wr_take & ((i_avs_address == fcs_pkg::FCS_OFS_CTRL)
                              | (i_avs_address == fcs_pkg::FCS_OFS_NUMER)
                              | (i_avs_address == fcs_pkg::FCS_OFS_DENOM));

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      run_reg    <= fcs_pkg::FCS_RUN_RST;
      speed_reg  <= fcs_pkg::FCS_SPEED_LOW;
      fb_sel_reg <= fcs_pkg::FCS_FB_NONE;
    end else if (wr_take && i_avs_address == fcs_pkg::FCS_OFS_CTRL) begin
      run_reg    <= i_avs_writedata[fcs_pkg::FCS_CTRL_RUN_BIT];
      speed_reg  <= fcs_pkg::fcs_speed_t'(i_avs_writedata[fcs_pkg::FCS_CTRL_SPEED_BIT]);
      fb_sel_reg <= fcs_pkg::fcs_fb_sel_t'(i_avs_writedata[fcs_pkg::FCS_CTRL_FB_LSB +: 2]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      numer_reg <= fcs_pkg::FCS_NUMER_RST;
      denom_reg <= fcs_pkg::FCS_DENOM_RST;
    end else if (wr_take && i_avs_address == fcs_pkg::FCS_OFS_NUMER) begin
      numer_reg <= i_avs_writedata[RW-1:0];
    end else if (wr_take && i_avs_address == fcs_pkg::FCS_OFS_DENOM) begin
      denom_reg <= i_avs_writedata[RW-1:0];
    end
  end

  // reference period measurement
  logic [PERIOD_W-1:0] per_cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [PERIOD_W-1:0] new_per;
  logic [PERIOD_W-1:0] per_delta;
  logic                stable_reg;
  logic                ref_ok_reg;

  assign new_per   = per_cnt_reg + PERIOD_W'(1);
  assign per_delta = (new_per >= period_reg) ? (new_per - period_reg) : (period_reg - new_per);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      per_cnt_reg <= '0;
      period_reg  <= '0;
      stable_reg  <= 1'b0;
      ref_ok_reg  <= 1'b0;
    end else if (ref_rise) begin
      per_cnt_reg <= '0;
      period_reg  <= new_per;
      // one cycle of jitter is normal from the pin sampling
      stable_reg  <= ref_ok_reg & (per_delta <= PERIOD_W'(1));
      ref_ok_reg  <= 1'b1;
    end else if (per_cnt_reg == TIMEOUT_LIM) begin
      stable_reg  <= 1'b0;
      ref_ok_reg  <= 1'b0;
    end else begin
      per_cnt_reg <= new_per;
    end
  end

  // configuration checks
  logic             ratio_ok;
  logic             fb_ok;
  logic             loop_mode;
  logic [TGT_W-1:0] target;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] min_tgt;
  logic             range_ok;
  logic             cfg_bad;
  logic             run_ok;

  assign ratio_ok = (numer_reg >= fcs_pkg::FCS_NUMER_MIN) & (numer_reg <= fcs_pkg::FCS_NUMER_MAX)
                  & (denom_reg >= fcs_pkg::FCS_DENOM_MIN) & (denom_reg <= fcs_pkg::FCS_DENOM_MAX);
  // only the zero-phase single-rate return exists here; a double-rate return is refused
  assign fb_ok     = (fb_sel_reg == fcs_pkg::FCS_FB_NONE) | (fb_sel_reg == fcs_pkg::FCS_FB_ONE_X);
  assign loop_mode = (fb_sel_reg == fcs_pkg::FCS_FB_ONE_X);
  assign target    = TGT_W'(period_reg) * TGT_W'(denom_reg);
  assign step      = ACC_W'({numer_reg, 1'b0});
  assign min_tgt   = (speed_reg == fcs_pkg::FCS_SPEED_HIGH) ? step : ACC_W'(step * LOW_HALF);
  assign range_ok  = ACC_W'(target) >= min_tgt;
  assign cfg_bad   = ~ratio_ok | ~fb_ok | (ref_ok_reg & stable_reg & ~range_ok);
  assign run_ok    = run_reg & ~cfg_bad & ref_ok_reg & stable_reg & ~cfg_touch;

  // alignment window: denominator reference periods
  logic [RW-1:0] ref_cnt_reg;
  logic          boundary;
  logic          align;

  assign boundary = run_ok & ref_rise & (ref_cnt_reg == denom_reg - RW'(1));
  assign align    = loop_mode & boundary;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ref_cnt_reg <= '0;
    end else if (!run_ok || boundary) begin
      ref_cnt_reg <= '0;
    end else if (ref_rise) begin
      ref_cnt_reg <= ref_cnt_reg + RW'(1);
    end
  end

  // phase accumulator: 2*numer per cycle, toggle each period*denom target crossing
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] acc_next;
  logic             wrap;
  logic             synth_reg;
  logic             synth_inv_reg;
  logic             synth_next;
  logic             synth_rise;

  assign acc_sum = acc_reg + step;
  assign wrap    = acc_sum >= ACC_W'(target);

  // half periods differ by at most one master cycle; exact only when 2*numer divides target
  always_comb begin
    acc_next   = acc_sum;
    synth_next = synth_reg;
    if (!run_ok) begin
      acc_next   = '0;
      synth_next = 1'b0;
    end else if (align) begin
      acc_next   = '0;
      synth_next = 1'b1;
    end else if (wrap) begin
      acc_next   = acc_sum - ACC_W'(target);
      synth_next = ~synth_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      synth_reg     <= 1'b0;
      synth_inv_reg <= 1'b0;
    end else begin
      synth_reg     <= synth_next;
      // both low while stopped so a consumer sees no runt edge
      synth_inv_reg <= run_ok & ~synth_next;
    end
  end

  // zero-phase copy updates on the same edge as the synthesized pair
  logic zero_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= ref_s;
    end
  end

  // coincidence check and lock
  logic [6:0] rise_cnt_reg;
  logic [6:0] numer_ext;
  logic       cnt_near;
  logic       window_ok_reg;
  logic       fb_seen_reg;
  logic       lock_reg;
  logic       lost_reg;
  logic       lock_next;
  logic       st_read;

  assign synth_rise = synth_next & ~synth_reg;
  assign numer_ext  = 7'(numer_reg);
  assign cnt_near   = (rise_cnt_reg + 7'h01 >= numer_ext) & (rise_cnt_reg <= numer_ext + 7'h01);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rise_cnt_reg <= 7'h00;
    end else if (!run_ok) begin
      rise_cnt_reg <= 7'h00;
    end else if (boundary) begin
      rise_cnt_reg <= synth_rise ? 7'h01 : 7'h00;
    end else if (synth_rise && rise_cnt_reg != RISE_SAT) begin
      rise_cnt_reg <= rise_cnt_reg + 7'h01;
    end
  end

  // first window after start is partial and is not judged
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      window_ok_reg <= 1'b0;
    end else if (!run_ok) begin
      window_ok_reg <= 1'b0;
    end else if (boundary) begin
      window_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fb_seen_reg <= 1'b0;
    end else if (fb_rise) begin
      fb_seen_reg <= 1'b1;
    end else if (cfg_touch || !ref_ok_reg) begin
      fb_seen_reg <= 1'b0;
    end
  end

  always_comb begin
    lock_next = lock_reg;
    if (!run_ok || (loop_mode && !fb_seen_reg)) begin
      lock_next = 1'b0;
    end else if (boundary) begin
      lock_next = window_ok_reg & cnt_near;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // sticky loss of lock, cleared by reading status; a new loss wins
  assign st_read = rd_take & (i_avs_address == fcs_pkg::FCS_OFS_STATUS);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lost_reg <= 1'b0;
    end else if (lock_reg && !lock_next) begin
      lost_reg <= 1'b1;
    end else if (st_read) begin
      lost_reg <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      fcs_pkg::FCS_OFS_CTRL: begin
        rd_mux[fcs_pkg::FCS_CTRL_RUN_BIT]     = run_reg;
        rd_mux[fcs_pkg::FCS_CTRL_SPEED_BIT]   = speed_reg;
        rd_mux[fcs_pkg::FCS_CTRL_FB_LSB +: 2] = fb_sel_reg;
      end
      fcs_pkg::FCS_OFS_NUMER: begin
        rd_mux[RW-1:0] = numer_reg;
      end
      fcs_pkg::FCS_OFS_DENOM: begin
        rd_mux[RW-1:0] = denom_reg;
      end
      fcs_pkg::FCS_OFS_STATUS: begin
        rd_mux[fcs_pkg::FCS_ST_LOCK_BIT]    = lock_reg;
        rd_mux[fcs_pkg::FCS_ST_REF_OK_BIT]  = ref_ok_reg;
        rd_mux[fcs_pkg::FCS_ST_FB_SEEN_BIT] = fb_seen_reg;
        rd_mux[fcs_pkg::FCS_ST_CFG_BAD_BIT] = cfg_bad;
        rd_mux[fcs_pkg::FCS_ST_RUN_BIT]     = run_ok;
        rd_mux[fcs_pkg::FCS_ST_LOST_BIT]    = lost_reg;
      end
      fcs_pkg::FCS_OFS_PERIOD: begin
        rd_mux[PERIOD_W-1:0] = period_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  assign o_avs_readdata             = rdata_reg;
  assign o_avs_waitrequest          = wait_reg;
  assign o_synth_clock_out          = synth_reg;
  assign o_synth_clock_out_inverted = synth_inv_reg;
  assign o_zero_phase_clock_out     = zero_reg;
  assign o_locked                   = lock_reg;

endmodule
`default_nettype wire

// ### logic/fcs_pkg.sv
// constants, field layout and types shared by the fractional clock synthesizer
package fcs_pkg;

  localparam int unsigned FCS_MCLK_HZ         = 20_000_000;
  localparam int unsigned FCS_ADDR_W          = 6;
  localparam int unsigned FCS_DATA_W          = 32;
  localparam int unsigned FCS_RATIO_W         = 6;
  localparam int unsigned FCS_PERIOD_W        = 16;
  localparam int unsigned FCS_REF_TIMEOUT_CYC = 65535;

  // register byte addresses
  localparam logic [5:0] FCS_OFS_CTRL   = 6'h00;
  localparam logic [5:0] FCS_OFS_NUMER  = 6'h04;
  localparam logic [5:0] FCS_OFS_DENOM  = 6'h08;
  localparam logic [5:0] FCS_OFS_STATUS = 6'h0C;
  localparam logic [5:0] FCS_OFS_PERIOD = 6'h10;

  // control fields
  localparam int unsigned FCS_CTRL_RUN_BIT   = 0;
  localparam int unsigned FCS_CTRL_SPEED_BIT = 1;
  localparam int unsigned FCS_CTRL_FB_LSB    = 2;

  // status fields
  localparam int unsigned FCS_ST_LOCK_BIT    = 0;
  localparam int unsigned FCS_ST_REF_OK_BIT  = 1;
  localparam int unsigned FCS_ST_FB_SEEN_BIT = 2;
  localparam int unsigned FCS_ST_CFG_BAD_BIT = 3;
  localparam int unsigned FCS_ST_RUN_BIT     = 4;
  localparam int unsigned FCS_ST_LOST_BIT    = 5;

  // reset values and legal ranges
  localparam logic       FCS_RUN_RST   = 1'b0;
  localparam logic       FCS_SPEED_RST = 1'b0;
  localparam logic [5:0] FCS_NUMER_RST = 6'h02;
  localparam logic [5:0] FCS_DENOM_RST = 6'h01;
  localparam logic [5:0] FCS_NUMER_MIN = 6'h02;
  localparam logic [5:0] FCS_NUMER_MAX = 6'h20;
  localparam logic [5:0] FCS_DENOM_MIN = 6'h01;
  localparam logic [5:0] FCS_DENOM_MAX = 6'h20;

  // shortest half period allowed in low speed range, in master clock cycles
  localparam int unsigned FCS_LOW_MIN_HALF_CYC = 2;

  typedef enum logic [1:0] {
    FCS_FB_NONE,
    FCS_FB_ONE_X,
    FCS_FB_TWO_X,
    FCS_FB_RSVD
  } fcs_fb_sel_t;

  typedef enum logic {
    FCS_SPEED_LOW,
    FCS_SPEED_HIGH
  } fcs_speed_t;

endpackage

// ### logic/fcs_sync2.sv
// two-flop synchronizer for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module fcs_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ### tb/fcs_synth_props.sv
// port-level assertions for the fractional clock synthesizer
`timescale 1ns/10ps
`default_nettype none
module fcs_synth_props #(
  parameter int unsigned REF_TIMEOUT_CYC = fcs_pkg::FCS_REF_TIMEOUT_CYC
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_reference_clock_in,
  input wire logic        i_feedback_clock_in,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_synth_clock_out,
  input wire logic        o_synth_clock_out_inverted,
  input wire logic        o_zero_phase_clock_out,
  input wire logic        o_locked
);
  logic [3:0]  rst_cnt;
  logic [16:0] idle_cnt;
  logic        synth_q;
  logic        zero_q;
  logic [5:0]  seg_cnt;
  logic [5:0]  hi_last;
  logic [5:0]  lo_last;
  logic [2:0]  lk_edges;
  logic [5:0]  seg_diff;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rst_cnt <= 4'h0;
    end else if (rst_cnt != 4'hF) begin
      rst_cnt <= rst_cnt + 4'h1;
    end
  end

  // saturating count of cycles with no reference activity
  always_ff @(posedge i_mclk) begin
    zero_q <= o_zero_phase_clock_out;
    if (!i_rst_n || o_zero_phase_clock_out != zero_q) begin
      idle_cnt <= 17'h00000;
    end else if (idle_cnt != 17'h1FFFF) begin
      idle_cnt <= idle_cnt + 17'h00001;
    end
  end

  // last high and low segment lengths of the synthesized clock
  always_ff @(posedge i_mclk) begin
    synth_q <= o_synth_clock_out;
    if (!i_rst_n) begin
      seg_cnt <= 6'h00;
      hi_last <= 6'h00;
      lo_last <= 6'h00;
    end else if (o_synth_clock_out != synth_q) begin
      seg_cnt <= 6'h01;
      if (synth_q) begin
        hi_last <= seg_cnt;
      end else begin
        lo_last <= seg_cnt;
      end
    end else if (seg_cnt != 6'h3F) begin
      seg_cnt <= seg_cnt + 6'h01;
    end
  end

  // segments right after lock may still carry start-up lengths
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !o_locked) begin
      lk_edges <= 3'h0;
    end else if (o_synth_clock_out != synth_q && lk_edges != 3'h7) begin
      lk_edges <= lk_edges + 3'h1;
    end
  end

  assign seg_diff = (hi_last >= lo_last) ? hi_last - lo_last : lo_last - hi_last;

  a_inv_while_locked: assert property (o_locked |-> o_synth_clock_out_inverted != o_synth_clock_out)
    else $error("inverted clock not complementary while locked");
  a_stopped_both_low: assert property (o_synth_clock_out == o_synth_clock_out_inverted |-> !o_synth_clock_out)
    else $error("synthesized clocks equal but not low");
  a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_low_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_zero_phase_copy: assert property (rst_cnt >= 4'h4 |-> o_zero_phase_clock_out == $past(i_reference_clock_in, 3))
    else $error("zero phase clock is not the reference delayed by three cycles");
  a_lock_toggles: assert property ($rose(o_synth_clock_out) && o_locked |-> ##[1:40] (!o_synth_clock_out || !o_locked))
    else $error("synthesized clock stuck high while locked");
  a_duty_equal: assert property ($rose(o_synth_clock_out) && lk_edges >= 3'h4 |-> seg_diff <= 6'h01)
    else $error("high and low times differ by more than one cycle");
  a_cfg_write_unlock: assert property (i_avs_write && o_avs_waitrequest && i_avs_byteenable[0]
      && i_avs_address inside {6'h00, 6'h04, 6'h08} |-> ##[1:3] !o_locked)
    else $error("lock held across a configuration write");
  a_ref_loss_unlock: assert property (idle_cnt > REF_TIMEOUT_CYC + 16 |-> !o_locked)
    else $error("lock held with reference missing");
endmodule

bind fcs_synth_top fcs_synth_props #(.REF_TIMEOUT_CYC(REF_TIMEOUT_CYC)) fcs_synth_props_i (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reference_clock_in(i_reference_clock_in),
  .i_feedback_clock_in(i_feedback_clock_in), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_synth_clock_out(o_synth_clock_out),
  .o_synth_clock_out_inverted(o_synth_clock_out_inverted),
  .o_zero_phase_clock_out(o_zero_phase_clock_out), .o_locked(o_locked));
`default_nettype wire

// ### tb/fcs_load_model.sv
// clock load model: counts synthesized edges and closes the feedback loop
`timescale 1ns/10ps
`default_nettype none
module fcs_load_model (
  input  wire logic        i_mclk,
  input  wire logic        i_clr,
  input  wire logic        i_loop_en,
  input  wire logic        i_synth,
  input  wire logic        i_synth_inv,
  input  wire logic        i_zero_phase,
  output logic             o_feedback,
  output logic      [15:0] o_rises,
  output logic      [15:0] o_inv_rises
);
  logic synth_q;
  logic inv_q;

  // no loop means the feedback pin sits tied low
  assign o_feedback = i_loop_en & i_zero_phase;

  always_ff @(posedge i_mclk) begin
    synth_q <= i_synth;
    inv_q <= i_synth_inv;
    if (i_clr) begin
      o_rises <= 16'h0000;
      o_inv_rises <= 16'h0000;
    end else begin
      o_rises <= o_rises + {15'h0000, i_synth & ~synth_q};
      o_inv_rises <= o_inv_rises + {15'h0000, i_synth_inv & ~inv_q};
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking testbench for the fractional clock synthesizer
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int P = 20;
  localparam int TO = 64;
  typedef struct packed {
    logic [5:0] n;
    logic [5:0] d;
    logic       spd;
    logic [1:0] fb;
    logic       loop;
    logic       run;
  } fcs_row_t;
  // reduced ratio terms, range limits, refused feedback selects
  fcs_row_t rows [11] = '{
    '{5, 3, 0, 1, 1, 1}, '{2, 1, 1, 0, 0, 1}, '{32, 32, 0, 0, 0, 1}, '{8, 1, 1, 1, 1, 1},
    '{8, 1, 0, 0, 0, 0}, '{1, 1, 1, 0, 0, 0}, '{33, 1, 1, 0, 0, 0}, '{2, 0, 1, 0, 0, 0},
    '{2, 33, 1, 0, 0, 0}, '{2, 1, 1, 2, 0, 0}, '{2, 1, 1, 3, 0, 0}};
  logic        i_mclk, i_rst_n, ref_clk, fb_clk, i_avs_read, i_avs_write;
  logic [5:0]  i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic [3:0]  i_avs_byteenable;
  logic        o_avs_waitrequest, synth, synth_inv, zero_phase, o_locked;
  logic        clr, loop_en, ref_on;
  logic [15:0] rises, inv_rises;
  int          ref_cnt, miscompares, checked;

  fcs_synth_top #(.REF_TIMEOUT_CYC(TO)) fcs_synth_top_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reference_clock_in(ref_clk),
    .i_feedback_clock_in(fb_clk), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_synth_clock_out(synth),
    .o_synth_clock_out_inverted(synth_inv), .o_zero_phase_clock_out(zero_phase),
    .o_locked(o_locked));
  fcs_load_model fcs_load_model_i (.i_mclk(i_mclk), .i_clr(clr), .i_loop_en(loop_en),
    .i_synth(synth), .i_synth_inv(synth_inv), .i_zero_phase(zero_phase),
    .o_feedback(fb_clk), .o_rises(rises), .o_inv_rises(inv_rises));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // reference at 30 percent duty to show the synthesized outputs do not follow it
  always @(posedge i_mclk) begin
    ref_cnt <= (ref_cnt == P - 1) ? 0 : ref_cnt + 1;
    ref_clk <= ref_on && (ref_cnt < 6);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_near(input string nm, input int e, input logic [15:0] g);
    checked++;
    if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    if (n >= 50) chk("bus answer", 0, 1);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic wait_lock(input int lim);
    int n;
    for (n = 0; n < lim && o_locked !== 1'b1; n++) @(posedge i_mclk);
  endtask

  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(50 * 80000);
    miscompares++;
    stop_test();
  end

  initial begin
    i_rst_n = 1'b0; ref_cnt = 0; ref_clk = 1'b0; ref_on = 1'b1; clr = 1'b0; loop_en = 1'b0;
    i_avs_read = 1'b0; i_avs_write = 1'b0; i_avs_address = 6'h00;
    i_avs_writedata = 32'h0; i_avs_byteenable = 4'hF; miscompares = 0; checked = 0;
    repeat (16) @(posedge i_mclk);
    chk("reset outputs", 32'h8, {o_avs_waitrequest, synth, synth_inv, o_locked});
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    bus(0, 6'h00, 0, 4'hF); chk("ctrl reset", 0, rd);
    bus(1, 6'h04, 5, 4'hE);
    bus(0, 6'h04, 0, 4'hF); chk("numer byteenable", 2, rd);
    bus(0, 6'h08, 0, 4'hF); chk("denom reset", 1, rd);
    bus(1, 6'h14, 32'hF, 4'hF);
    bus(0, 6'h14, 0, 4'hF); chk("unmapped", 0, rd);
    foreach (rows[i]) begin
      loop_en <= rows[i].loop;
      bus(1, 6'h04, {26'h0, rows[i].n}, 4'hF);
      bus(1, 6'h08, {26'h0, rows[i].d}, 4'hF);
      bus(1, 6'h00, {28'h0, rows[i].fb, rows[i].spd, 1'b1}, 4'hF);
      if (rows[i].run) begin
        wait_lock(4000);
        chk("locked", 1, o_locked);
        while (ref_cnt != 0) @(posedge i_mclk);
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
        repeat (4 * P * rows[i].d) @(posedge i_mclk);
        chk_near("rises", 4 * rows[i].n, rises);
        chk_near("inverted rises", 4 * rows[i].n, inv_rises);
      end else begin
        repeat (300) @(posedge i_mclk);
        chk("clocks off", 0, {synth, synth_inv});
      end
      bus(0, 6'h0C, 0, 4'hF);
      chk("status", {rows[i].run, !rows[i].run, 1'b1, rows[i].run},
          {rd[4:3], rd[1:0]});
    end
    bus(0, 6'h10, 0, 4'hF); chk("period", P, rd);
    // single-rate feedback selected but loop left open
    loop_en <= 1'b0;
    bus(1, 6'h00, 32'h7, 4'hF);
    repeat (600) @(posedge i_mclk);
    chk("lock without feedback", 0, o_locked);
    bus(1, 6'h00, 32'h3, 4'hF);
    wait_lock(2000);
    chk("locked free running", 1, o_locked);
    ref_on <= 1'b0;
    repeat (TO + 40) @(posedge i_mclk);
    chk("lock after loss", 0, {o_locked, synth, synth_inv});
    bus(0, 6'h0C, 0, 4'hF); chk("loss sticky", 1, rd[5]);
    bus(0, 6'h0C, 0, 4'hF); chk("loss cleared", 0, rd[5]);
    ref_on <= 1'b1;
    wait_lock(2000);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    chk("mid reset", 0, {o_locked, synth, synth_inv});
    bus(0, 6'h00, 0, 4'hF); chk("ctrl after reset", 0, rd);
    stop_test();
  end
endmodule
`default_nettype wire
